// ### bench/lqd_far_end.sv
/*
 * Far-end link partner model: cable energy, link status and DSP values.
 * Assumes the bench picks cable energy, negotiation mode and gain level.
 */
`default_nettype none
module lqd_far_end (
    input  wire logic               clk,
    input  wire logic               energy_on,
    input  wire logic               autoneg,
    input  wire logic [7:0]         gain_v,
    input  wire logic [7:0]         err_v,
    output logic                    line_activity,
    output lqd_pkg::lqd_link_t      link,
    output lqd_pkg::lqd_dsp_t       dsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Energy follows the bench; link is 100Mb with swapped pairs
    assign line_activity = energy_on;
    assign link = '{link_up: 1'b1, speed100: 1'b1, an_done: autoneg, par_det: 1'b0, pol_rev: 1'b1, mdix: 1'b1};
    // Error sample held by the bench so window sums are exact
    always_ff @(posedge clk) begin
        dsp <= '{freq_ctl: 8'h85, freq_off: 8'h12, blw: 8'hf0, gain: gain_v, eq_c1: 8'h3c,
                 err: err_v, cable_len: 16'h0123};
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
/*
 * Self-checking bench for the diagnostics block over its register port.
 * Assumes the far-end model supplies link status and DSP values.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, energy_on = 1'b0, autoneg = 1'b1, rd_q = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [7:0]  gain_v, err_v = 8'h00, pv [0:4];
    logic [31:0] vsum;
    logic        line_activity, low_power, energy_pulse_tx, power_up_start, tdr_tx_pair, tdr_rx_pair, int_n;
    lqd_pkg::lqd_link_t link;
    lqd_pkg::lqd_dsp_t  dsp;
    logic [15:0] exp_q[$];
    string       name_q[$];
    int          fails = 0, cmp_count = 0, p, ev;

    lqd_far_end far_u (.clk(clk), .energy_on(energy_on), .autoneg(autoneg), .gain_v(gain_v), .err_v(err_v),
                       .line_activity(line_activity), .link(link), .dsp(dsp));
    lqd_diag #(.MS_CYCLES(20), .ED_GAP_CYC(16)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_activity(line_activity), .link(link), .dsp(dsp), .low_power(low_power),
        .energy_pulse_tx(energy_pulse_tx), .power_up_start(power_up_start), .tdr_tx_pair(tdr_tx_pair),
        .tdr_rx_pair(tdr_rx_pair), .int_n(int_n));

    always #20 clk = ~clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp16(string what, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    // Read data lands on the edge after the strobe; check it half a cycle later
    always @(posedge clk) rd_q <= reg_rd;
    always @(negedge clk) if (rd_q) cmp16(name_q.pop_front(), exp_q.pop_front(), reg_rdata);

    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [4:0] a, logic [15:0] e, string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        name_q.push_back(what);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // Bounded wait for a power state output
    task automatic wait_hi(bit up);
        int n;
        n = 0;
        while ((up ? power_up_start : energy_pulse_tx) !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        cmp_count++;
        if (n == 60) begin
            fails++;
            $display("unexpected %s expected 1 seen 0", up ? "power_up_start" : "energy_pulse_tx");
            final_report();
        end
    endtask

    initial begin
        void'($urandom(32'h932d));
        gain_v = 8'($urandom_range(254, 1));
        pv = '{8'h3c, gain_v, 8'hf0, 8'h12, 8'h85};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmp16("reset outputs", 16'h0001, {10'h000, low_power, energy_pulse_tx, power_up_start,
              tdr_tx_pair, tdr_rx_pair, int_n});
        wr(5'h13, 16'h0002);
        for (p = 0; p < 5; p++) begin
            wr(5'h1e, 16'(p << 9) | 16'h0100);
            rd(5'h1e, (p == 1) ? 16'h00ff : 16'h007f, "high threshold");
            wr(5'h1e, 16'(p << 9));
            rd(5'h1e, (p == 1) ? 16'h0000 : 16'h0080, "low threshold");
            wr(5'h1e, 16'h2000 | 16'(p << 9));
            rd(5'h1e, {8'h00, pv[p]}, "sampled parameter");
        end
        $display("thresholds and samples done");
        wr(5'h1d, 16'h8000);
        wr(5'h1e, 16'h1300 | {8'h00, gain_v});
        rd(5'h1d, 16'h8000, "monitor at equality");
        wr(5'h1e, 16'h1300 | {8'h00, gain_v - 8'h01});
        wr(5'h1e, 16'h1405);
        rd(5'h1d, 16'h8018, "monitor on excess");
        wr(5'h1e, 16'h1300 | {8'h00, gain_v});
        wr(5'h1e, 16'h1480);
        rd(5'h1d, 16'h8018, "monitor sticky");
        rd(5'h1d, 16'h8000, "monitor cleared");
        wr(5'h1d, 16'h0000);
        wr(5'h1e, 16'h1300 | {8'h00, gain_v - 8'h01});
        rd(5'h1d, 16'h0000, "monitor disabled");
        $display("monitor done");
        // Held error sample: each window sum is window cycles times its square
        @(posedge clk);
        err_v <= 8'($urandom);
        @(posedge clk);
        ev = $signed(err_v);
        for (p = 1; p < 4; p += 2) begin
            wr(5'h1a, 16'h8000 | 16'(p << 1));
            repeat (400) @(posedge clk);
            vsum = 32'(2 * (p + 1) * 20 * ev * ev);
            rd(5'h1b, vsum[15:0], "variance low");
            rd(5'h1b, vsum[31:16], "variance high");
        end
        $display("variance done");
        rd(5'h14, 16'h0123, "cable length");
        wr(5'h15, 16'h0100);
        rd(5'h15, 16'h0185, "frequency control");
        wr(5'h15, 16'h0000);
        rd(5'h15, 16'h0012, "frequency offset");
        wr(5'h16, 16'h3000);
        @(negedge clk);
        cmp16("tdr pairs", 16'h0003, {14'h0000, tdr_tx_pair, tdr_rx_pair});
        wr(5'h13, 16'h0000);
        rd(5'h10, 16'h5001, "status autoneg");
        rd(5'h1a, 16'h0010, "ten meg status");
        autoneg <= 1'b0;
        repeat (2) @(posedge clk);
        rd(5'h10, 16'h4001, "status forced");
        $display("status done");
        wr(5'h1d, 16'h8000);
        wait_hi(1'b0);
        cmp16("low power", 16'h0001, {15'h0000, low_power});
        @(posedge clk);
        energy_on <= 1'b1;
        wait_hi(1'b1);
        $display("energy detect done");
        // Monitor and energy events are both pending by now
        wr(5'h11, 16'h0003);
        wr(5'h12, 16'h0003);
        @(negedge clk);
        cmp16("int_n asserted", 16'h0000, {15'h0000, int_n});
        rd(5'h12, 16'h0303, "interrupt status");
        @(negedge clk);
        cmp16("int_n released", 16'h0001, {15'h0000, int_n});
        $display("interrupt done");
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire

// ### design/lqd_diag.sv
/*
 * Link quality diagnostics of one port: energy detect power state, status
 * bits, cable length and frequency offset view, variance accumulator, link
 * quality monitor with indirect thresholds, reflectometry pair selection and
 * the interrupt status register behind the management register port.
 * Assumes DSP values and link status arrive on clk; line_activity is async.
 */
`default_nettype none

module lqd_diag #(
    parameter int MS_CYCLES  = lqd_pkg::MS_CYC,
    parameter int ED_GAP_CYC = lqd_pkg::ED_GAP_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [4:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    input  wire logic              line_activity,
    input  wire lqd_pkg::lqd_link_t link,
    input  wire lqd_pkg::lqd_dsp_t  dsp,
    output logic                   low_power,
    output logic                   energy_pulse_tx,
    output logic                   power_up_start,
    output logic                   tdr_tx_pair,
    output logic                   tdr_rx_pair,
    output logic                   int_n
);

    typedef struct packed {
        lqd_pkg::lqd_ed_t             ed;
        logic [19:0]                  ed_cnt;
        logic [1:0]                   act_sync;
        logic [1:0]                   page;
        logic [1:0]                   int_ctrl;
        logic [7:0]                   int_mask;
        logic [1:0]                   int_stat;
        logic                         ed_en;
        logic                         freq_sel;
        logic                         var_en;
        logic [1:0]                   var_tsel;
        logic [31:0]                  var_acc;
        logic [31:0]                  var_sum;
        logic                         var_upper;
        logic [15:0]                  var_hold;
        logic [19:0]                  ms_cnt;
        logic [3:0]                   ms_left;
        logic                         lq_en;
        logic [9:0]                   warn;
        logic [4:0][1:0][7:0]         thr;
        logic [7:0]                   lq_rd;
        logic [1:0]                   tdr_sel;
        logic [15:0]                  rdata;
    } lqd_state_t;

    lqd_state_t s;
    lqd_state_t next_s;

    logic                    diag_page;
    logic                    link100;
    logic                    pol_valid;
    logic [4:0][7:0]         pv;
    logic [9:0]              hit;
    logic                    cmp_on;
    logic [15:0]             rd_mux;
    logic                    wr_diag;
    logic                    rd_diag;
    logic [15:0]             err_sq;

    // Shared qualifiers
    assign diag_page = (s.page == lqd_pkg::PAGE_DIAG);
    assign link100   = link.link_up & link.speed100;
    assign pol_valid = ~link.speed100 | (link.an_done & ~link.par_det);
    assign pv        = {dsp.freq_ctl, dsp.freq_off, dsp.blw, dsp.gain, dsp.eq_c1};
    assign cmp_on    = s.lq_en & link.link_up;
    assign wr_diag   = reg_wr & diag_page;
    assign rd_diag   = reg_rd & diag_page;
    assign err_sq    = 16'($signed(dsp.err) * $signed(dsp.err));

    // Window comparators, strict excess only so an extreme threshold never fires
    genvar gp;
    generate
        for (gp = 0; gp < lqd_pkg::NPARAM; gp++) begin : g_cmp
            logic over;
            logic under;
            if (gp == lqd_pkg::P_GAIN) begin : g_uns
                assign over  = pv[gp] > s.thr[gp][1];
                assign under = pv[gp] < s.thr[gp][0];
            end else begin : g_sgn
                assign over  = $signed(pv[gp]) > $signed(s.thr[gp][1]);
                assign under = $signed(pv[gp]) < $signed(s.thr[gp][0]);
            end
            assign hit[2*gp+1] = cmp_on & over;
            assign hit[2*gp]   = cmp_on & under;
        end
    endgenerate

    // Read data decode; values outside their validity window read zero
    always_comb begin
        rd_mux = 16'h0000;
        if (reg_addr == lqd_pkg::A_PAGE) begin
            rd_mux = {14'h0000, s.page};
        end else if (!diag_page) begin
            unique case (reg_addr)
                lqd_pkg::A_PHY_STATUS: begin
                    rd_mux[lqd_pkg::B_STS_MDIX]  = link.mdix;
                    rd_mux[lqd_pkg::B_STS_POL]   = link.pol_rev & pol_valid;
                    rd_mux[lqd_pkg::B_STS_SPD10] = ~link.speed100;
                    rd_mux[lqd_pkg::B_STS_LINK]  = link.link_up;
                end
                lqd_pkg::A_INT_CTRL: rd_mux = {14'h0000, s.int_ctrl};
                lqd_pkg::A_INT_MASK: rd_mux = {6'h00, s.int_stat, s.int_mask};
                lqd_pkg::A_TENMEG:   rd_mux[lqd_pkg::B_TEN_POL] = link.pol_rev & pol_valid;
                lqd_pkg::A_ENERGY_DETECT_CONTROL:     rd_mux[lqd_pkg::B_EN] = s.ed_en;
                default:             rd_mux = 16'h0000;
            endcase
        end else begin
            unique case (reg_addr)
                lqd_pkg::A_CABLE:    rd_mux = link100 ? dsp.cable_len : 16'h0000;
                lqd_pkg::A_FREQ: begin
                    rd_mux[lqd_pkg::B_FREQ_SEL] = s.freq_sel;
                    if (link100) begin
                        rd_mux[7:0] = s.freq_sel ? dsp.freq_ctl : dsp.freq_off;
                    end
                end
                lqd_pkg::A_TDR: begin
                    rd_mux[lqd_pkg::B_TDR_TXSEL] = s.tdr_sel[1];
                    rd_mux[lqd_pkg::B_TDR_RXSEL] = s.tdr_sel[0];
                end
                lqd_pkg::A_VAR_CTRL: begin
                    rd_mux[lqd_pkg::B_EN] = s.var_en;
                    rd_mux[lqd_pkg::B_VAR_TSEL +: 2] = s.var_tsel;
                end
                lqd_pkg::A_VAR_DATA: rd_mux = s.var_upper ? s.var_hold : s.var_sum[15:0];
                lqd_pkg::A_QUALITY_MONITOR_CONTROL:     rd_mux = {s.lq_en, 5'h00, s.warn};
                lqd_pkg::A_QUALITY_DATA_INDIRECT:     rd_mux = {8'h00, s.lq_rd};
                default:             rd_mux = 16'h0000;
            endcase
        end
    end

    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.act_sync = {s.act_sync[0], line_activity};

        // Energy detect power state machine
        unique case (s.ed)
            lqd_pkg::ED_ON: begin
                next_s.ed_cnt = 20'h00000;
                if (s.ed_en && !s.act_sync[1]) begin
                    next_s.ed = lqd_pkg::ED_LOW;
                end
            end
            lqd_pkg::ED_LOW: begin
                next_s.ed_cnt = s.ed_cnt + 20'h00001;
                if (!s.ed_en || s.act_sync[1]) begin
                    next_s.ed = lqd_pkg::ED_WAKE;
                end else if (s.ed_cnt == 20'(ED_GAP_CYC - 1)) begin
                    next_s.ed     = lqd_pkg::ED_PULSE;
                    next_s.ed_cnt = 20'h00000;
                end
            end
            lqd_pkg::ED_PULSE: begin
                // Pulse is sent even if activity appears meanwhile
                next_s.ed_cnt = s.ed_cnt + 20'h00001;
                if (s.ed_cnt == 20'(lqd_pkg::ED_PULSE_CYC - 1)) begin
                    next_s.ed     = lqd_pkg::ED_LOW;
                    next_s.ed_cnt = 20'h00000;
                end
            end
            lqd_pkg::ED_WAKE: begin
                next_s.ed     = lqd_pkg::ED_ON;
                next_s.ed_cnt = 20'h00000;
            end
            default: begin
                next_s.ed     = lqd_pkg::ED_ON;
                next_s.ed_cnt = 20'h00000;
            end
        endcase

        // Variance accumulation over the selected window of 2, 4, 6 or 8 ms
        if (s.ms_cnt == 20'(MS_CYCLES - 1)) begin
            next_s.ms_cnt = 20'h00000;
            if (s.ms_left == 4'h0) begin
                next_s.ms_left = {1'b0, s.var_tsel, 1'b1};
                next_s.var_sum = s.var_acc;
                next_s.var_acc = 32'h00000000;
            end else begin
                next_s.ms_left = s.ms_left - 4'h1;
            end
        end else begin
            next_s.ms_cnt = s.ms_cnt + 20'h00001;
        end
        // Boundary sample opens the new window, so no cycle is dropped
        if (s.var_en && link100) begin
            next_s.var_acc = next_s.var_acc + {16'h0000, err_sq};
        end

        // Register reads with side effects
        if (rd_diag && reg_addr == lqd_pkg::A_VAR_DATA) begin
            // Upper half is frozen at the first read so the pair is coherent
            next_s.var_upper = ~s.var_upper;
            next_s.var_hold  = s.var_sum[31:16];
        end
        if (rd_diag && reg_addr == lqd_pkg::A_QUALITY_MONITOR_CONTROL) begin
            next_s.warn = 10'h000;
        end
        if (reg_rd && !diag_page && reg_addr == lqd_pkg::A_INT_MASK) begin
            next_s.int_stat = 2'h0;
        end
        if (reg_rd) begin
            next_s.rdata = rd_mux;
        end

        // Register writes
        if (reg_wr && reg_addr == lqd_pkg::A_PAGE) begin
            next_s.page = reg_wdata[1:0];
        end
        if (reg_wr && !diag_page) begin
            unique case (reg_addr)
                lqd_pkg::A_INT_CTRL: next_s.int_ctrl = reg_wdata[1:0];
                lqd_pkg::A_INT_MASK: next_s.int_mask = reg_wdata[7:0];
                lqd_pkg::A_ENERGY_DETECT_CONTROL:     next_s.ed_en = reg_wdata[lqd_pkg::B_EN];
                default:             next_s.page = next_s.page;
            endcase
        end
        if (wr_diag) begin
            unique case (reg_addr)
                lqd_pkg::A_FREQ:     next_s.freq_sel = reg_wdata[lqd_pkg::B_FREQ_SEL];
                lqd_pkg::A_TDR: begin
                    next_s.tdr_sel = {reg_wdata[lqd_pkg::B_TDR_TXSEL], reg_wdata[lqd_pkg::B_TDR_RXSEL]};
                end
                lqd_pkg::A_VAR_CTRL: begin
                    next_s.var_en   = reg_wdata[lqd_pkg::B_EN];
                    next_s.var_tsel = reg_wdata[lqd_pkg::B_VAR_TSEL +: 2];
                end
                lqd_pkg::A_QUALITY_MONITOR_CONTROL:     next_s.lq_en = reg_wdata[lqd_pkg::B_EN];
                lqd_pkg::A_QUALITY_DATA_INDIRECT: begin
                    if (reg_wdata[lqd_pkg::B_LQ_SAMPLE]) begin
                        // Selectors above the last parameter read zero
                        next_s.lq_rd = (reg_wdata[11:9] < 3'h5) ? pv[reg_wdata[11:9]] : 8'h00;
                    end else if (reg_wdata[11:9] < 3'h5) begin
                        if (reg_wdata[lqd_pkg::B_LQ_WRITE]) begin
                            next_s.thr[reg_wdata[11:9]][reg_wdata[lqd_pkg::B_LQ_HI]] = reg_wdata[7:0];
                            next_s.lq_rd = reg_wdata[7:0];
                        end else begin
                            next_s.lq_rd = s.thr[reg_wdata[11:9]][reg_wdata[lqd_pkg::B_LQ_HI]];
                        end
                    end else begin
                        next_s.lq_rd = 8'h00;
                    end
                end
                default:             next_s.page = next_s.page;
            endcase
        end

        // Hardware events win over the read that clears them
        next_s.warn = next_s.warn | hit;
        if (|hit) begin
            next_s.int_stat[lqd_pkg::I_LQ] = 1'b1;
        end
        if (s.ed == lqd_pkg::ED_WAKE || (s.ed == lqd_pkg::ED_ON && next_s.ed == lqd_pkg::ED_LOW)) begin
            next_s.int_stat[lqd_pkg::I_ED] = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s          <= '0;
            s.ed       <= lqd_pkg::ED_ON;
            s.ms_left  <= 4'h1;
            for (int p = 0; p < lqd_pkg::NPARAM; p++) begin
                s.thr[p][1] <= (p == lqd_pkg::P_GAIN) ? lqd_pkg::U_MAX : lqd_pkg::S_MAX;
                s.thr[p][0] <= (p == lqd_pkg::P_GAIN) ? lqd_pkg::U_MIN : lqd_pkg::S_MIN;
            end
        end else begin
            s <= next_s;
        end
    end

    // Outputs, all decoded from state flops
    assign reg_rdata       = s.rdata;
    assign low_power       = (s.ed == lqd_pkg::ED_LOW) | (s.ed == lqd_pkg::ED_PULSE);
    assign energy_pulse_tx = (s.ed == lqd_pkg::ED_PULSE);
    assign power_up_start  = (s.ed == lqd_pkg::ED_WAKE);
    assign tdr_tx_pair     = s.tdr_sel[1];
    assign tdr_rx_pair     = s.tdr_sel[0];
    // Pin only pulls low when both enables are set in the control register
    assign int_n = ~(s.int_ctrl[lqd_pkg::B_INT_EN] & s.int_ctrl[lqd_pkg::B_INT_OE]
                     & |(s.int_stat & s.int_mask[1:0]));

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_int_release: assert property (
        reg_rd && !diag_page && reg_addr == lqd_pkg::A_INT_MASK && !(|hit) && s.ed != lqd_pkg::ED_WAKE
        && !(s.ed == lqd_pkg::ED_ON && next_s.ed == lqd_pkg::ED_LOW) |=> int_n)
        else $error("interrupt pin not released after status read");

    a_warn_sticky: assert property (
        s.warn[0] && !(rd_diag && reg_addr == lqd_pkg::A_QUALITY_MONITOR_CONTROL) |=> s.warn[0])
        else $error("warning bit lost before monitor read");

    a_warn_gate: assert property (
        !cmp_on && rd_diag && reg_addr == lqd_pkg::A_QUALITY_MONITOR_CONTROL |=> s.warn == 10'h000)
        else $error("warning while monitor disabled or link down");

    a_gain_equal: assert property (
        dsp.gain == s.thr[lqd_pkg::P_GAIN][1] |-> !hit[2*lqd_pkg::P_GAIN+1])
        else $error("equal gain raised a warning");

    a_thr_reset: assert property (
        $rose(rst_n) |-> s.thr[lqd_pkg::P_GAIN][1] == lqd_pkg::U_MAX && s.thr[0][0] == lqd_pkg::S_MIN)
        else $error("thresholds not at extremes after reset");

    a_power_up: assert property (
        s.ed == lqd_pkg::ED_LOW && s.act_sync[1] |=> power_up_start ##1 !low_power)
        else $error("activity did not start power up");

    a_pulse_len: assert property (
        $rose(energy_pulse_tx) |-> energy_pulse_tx [*5] ##1 !energy_pulse_tx)
        else $error("energy pulse width wrong");

    a_pol_gate: assert property (
        reg_rd && !diag_page && reg_addr == lqd_pkg::A_PHY_STATUS && link.speed100 && link.par_det
        |=> !reg_rdata[lqd_pkg::B_STS_POL])
        else $error("polarity shown in parallel detected 100Mb");

    a_var_pair: assert property (
        rd_diag && reg_addr == lqd_pkg::A_VAR_DATA && !s.var_upper
        |=> s.var_upper && s.var_hold == $past(s.var_sum[31:16]))
        else $error("variance upper half not held");

    a_lq_sample: assert property (
        wr_diag && reg_addr == lqd_pkg::A_QUALITY_DATA_INDIRECT && reg_wdata[15:8] == 8'h24
        |=> s.lq_rd == $past(dsp.blw))
        else $error("baseline wander sample wrong");

    c_ed_cycle:  cover property (s.ed == lqd_pkg::ED_LOW ##1 energy_pulse_tx [*5] ##1 s.ed == lqd_pkg::ED_LOW);
    c_lq_int:    cover property (|hit ##1 !int_n);
    c_var_two:   cover property (rd_diag && reg_addr == lqd_pkg::A_VAR_DATA ##[1:20]
                                 rd_diag && reg_addr == lqd_pkg::A_VAR_DATA);

endmodule

`default_nettype wire

// ### design/lqd_pkg.sv
/*
 * Package for the link quality diagnostics block: management register
 * offsets, field positions, reset values, timing constants and the structs
 * that carry link status and DSP parameters into the block.
 * Assumes a 25 MHz management clock and 5-bit register addresses.
 */
`default_nettype none

package lqd_pkg;

    // Clock and time base
    localparam int CLK_NS        = 40;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYC        = MS_NS / CLK_NS;
    localparam int ED_GAP_US     = 1000;
    localparam int ED_GAP_CYC    = ED_GAP_US * 1000 / CLK_NS;
    localparam int ED_PULSE_NS   = 200;
    localparam int ED_PULSE_CYC  = (ED_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // Register offsets (default page unless noted)
    localparam logic [4:0] A_PHY_STATUS = 5'h10;
    localparam logic [4:0] A_INT_CTRL   = 5'h11;
    localparam logic [4:0] A_INT_MASK   = 5'h12;
    localparam logic [4:0] A_PAGE       = 5'h13;
    localparam logic [4:0] A_CABLE      = 5'h14;  // Page 2
    localparam logic [4:0] A_FREQ       = 5'h15;  // Page 2
    localparam logic [4:0] A_TDR        = 5'h16;  // Page 2
    localparam logic [4:0] A_TENMEG     = 5'h1a;
    localparam logic [4:0] A_VAR_CTRL   = 5'h1a;  // Page 2
    localparam logic [4:0] A_VAR_DATA   = 5'h1b;  // Page 2
    localparam logic [4:0] A_ENERGY_DETECT_CONTROL       = 5'h1d;
    localparam logic [4:0] A_QUALITY_MONITOR_CONTROL       = 5'h1d;  // Page 2
    localparam logic [4:0] A_QUALITY_DATA_INDIRECT       = 5'h1e;  // Page 2
    localparam logic [1:0] PAGE_DIAG    = 2'h2;

    // Field positions
    localparam int B_STS_MDIX   = 14;
    localparam int B_STS_POL    = 12;
    localparam int B_STS_SPD10  = 1;
    localparam int B_STS_LINK   = 0;
    localparam int B_TEN_POL    = 4;
    localparam int B_INT_EN     = 1;
    localparam int B_INT_OE     = 0;
    localparam int B_EN         = 15;     // Enable bit of ENERGY_DETECT_CONTROL, VAR_CTRL, QUALITY_MONITOR_CONTROL
    localparam int B_FREQ_SEL   = 8;
    localparam int B_TDR_TXSEL  = 13;
    localparam int B_TDR_RXSEL  = 12;
    localparam int B_LQ_SAMPLE  = 13;
    localparam int B_LQ_WRITE   = 12;
    localparam int B_LQ_PSEL    = 9;
    localparam int B_LQ_HI      = 8;
    localparam int B_VAR_TSEL   = 1;
    localparam int I_LQ         = 0;      // Interrupt source index
    localparam int I_ED         = 1;

    // Monitored parameter indices and threshold reset values
    localparam int NPARAM       = 5;
    localparam int P_GAIN       = 1;
    localparam logic [7:0] S_MAX = 8'h7f;
    localparam logic [7:0] S_MIN = 8'h80;
    localparam logic [7:0] U_MAX = 8'hff;
    localparam logic [7:0] U_MIN = 8'h00;

    typedef enum logic [3:0] {
        ED_ON    = 4'b0001,
        ED_LOW   = 4'b0010,
        ED_PULSE = 4'b0100,
        ED_WAKE  = 4'b1000
    } lqd_ed_t;

    typedef struct packed {
        logic link_up;
        logic speed100;
        logic an_done;
        logic par_det;
        logic pol_rev;
        logic mdix;
    } lqd_link_t;

    typedef struct packed {
        logic [7:0]  freq_ctl;
        logic [7:0]  freq_off;
        logic [7:0]  blw;
        logic [7:0]  gain;
        logic [7:0]  eq_c1;
        logic [7:0]  err;
        logic [15:0] cable_len;
    } lqd_dsp_t;

endpackage

`default_nettype wire
